//--- verilog/rta_trim_alarm.v
`include "rta_trim_alarm_map.vh"

module rta_trim_alarm #(parameter [15:0] PULSES_NOMINAL = `RTA_PULSES_NOMINAL) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       ser_ce,
  input  wire       ser_sclk,
  input  wire       ser_sio_i,
  output reg        ser_sio_o,
  output reg        ser_sio_oe,
  input  wire       osc_in,
  input  wire [6:0] sec_bcd,
  input  wire [6:0] cur_minute,
  input  wire [5:0] cur_hour,
  input  wire [2:0] cur_weekday,
  output reg        second_tick,
  output reg        weekly_alarm_match,
  output reg        daily_alarm_match,
  output reg        trim_active
);

  // ****************************************************************
  // Reset release and pin synchronisers.
  // ****************************************************************
  reg  [1:0] rst_q;
  reg  [1:0] ce_sync_q;
  reg  [1:0] sclk_sync_q;
  reg  [1:0] sio_sync_q;
  reg  [1:0] osc_sync_q;
  reg        ce_prev_q;
  reg        sclk_prev_q;
  reg        osc_prev_q;
  wire       rst_n = rst_q[1];

  // Reset is asserted at once and released two edges later.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  // Each serial pin and osc_in passes two flops; edge detectors only see the second.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ce_sync_q   <= 2'b00;
      sclk_sync_q <= 2'b00;
      sio_sync_q  <= 2'b00;
      osc_sync_q  <= 2'b00;
      ce_prev_q   <= 1'b0;
      sclk_prev_q <= 1'b0;
      osc_prev_q  <= 1'b0;
    end
    else
    begin
      ce_sync_q   <= {ce_sync_q[0], ser_ce};
      sclk_sync_q <= {sclk_sync_q[0], ser_sclk};
      sio_sync_q  <= {sio_sync_q[0], ser_sio_i};
      osc_sync_q  <= {osc_sync_q[0], osc_in};
      ce_prev_q   <= ce_sync_q[1];
      sclk_prev_q <= sclk_sync_q[1];
      osc_prev_q  <= osc_sync_q[1];
    end
  end

  wire ce     = ce_sync_q[1];
  wire ce_up  = ce & ~ce_prev_q;
  wire sck_up = sclk_sync_q[1] & ~sclk_prev_q;
  wire sck_dn = ~sclk_sync_q[1] & sclk_prev_q;
  wire osc_up = osc_sync_q[1] & ~osc_prev_q;

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  reg  [7:0] trim_q;
  reg  [6:0] wk_minute_q;
  reg  [5:0] wk_hour_q;
  reg  [6:0] wk_daymask_q;
  reg  [6:0] dy_minute_q;
  reg  [5:0] dy_hour_q;

  // Read data; unimplemented bits and foreign addresses read zero.
  function [7:0] reg_read;
    input [3:0] a;
    begin
      case (a)
        `RTA_ADDR_TRIM:       reg_read = trim_q;
        `RTA_ADDR_WK_MINUTE:  reg_read = {1'b0, wk_minute_q};
        `RTA_ADDR_WK_HOUR:    reg_read = {2'b00, wk_hour_q};
        `RTA_ADDR_WK_DAYMASK: reg_read = {1'b0, wk_daymask_q};
        `RTA_ADDR_DY_MINUTE:  reg_read = {1'b0, dy_minute_q};
        `RTA_ADDR_DY_HOUR:    reg_read = {2'b00, dy_hour_q};
        default:              reg_read = 8'h00;
      endcase
    end
  endfunction

  // ****************************************************************
  // Three-wire serial slave.
  // ****************************************************************
  reg        in_rise_q;
  reg  [2:0] bit_cnt_q;
  reg  [6:0] in_sh_q;
  reg  [7:0] out_sh_q;
  reg        data_ph_q;
  reg        rd_q;
  reg        single_q;
  reg  [3:0] addr_q;

  wire       in_edge  = ce & (in_rise_q ? sck_up : sck_dn);
  wire       out_edge = ce & (in_rise_q ? sck_dn : sck_up);
  wire [7:0] in_byte  = {in_sh_q, sio_sync_q[1]};
  wire       byte_end = in_edge & (bit_cnt_q == 3'h7);
  wire [3:0] addr_nx  = addr_q + 4'h1;

  // Bytes are taken MSB first; the first byte after CE is a command.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_rise_q  <= 1'b0;
      bit_cnt_q  <= 3'h0;
      in_sh_q    <= 7'h00;
      out_sh_q   <= 8'h00;
      data_ph_q  <= 1'b0;
      rd_q       <= 1'b0;
      single_q   <= 1'b0;
      addr_q     <= 4'h0;
      ser_sio_o  <= 1'b0;
      ser_sio_oe <= 1'b0;
    end
    else if (!ce)
    begin
      bit_cnt_q  <= 3'h0;
      data_ph_q  <= 1'b0;
      ser_sio_oe <= 1'b0;
    end
    else
    begin
      if (ce_up)
        in_rise_q <= sclk_sync_q[1];
      if (in_edge)
      begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        in_sh_q   <= in_byte[6:0];
      end
      if (out_edge && data_ph_q && rd_q)
      begin
        ser_sio_o <= out_sh_q[7];
        out_sh_q  <= {out_sh_q[6:0], 1'b0};
      end
      if (byte_end)
      begin
        if (!data_ph_q)
        begin
          addr_q     <= in_byte[7:4];
          rd_q       <= in_byte[`RTA_FMT_READ_BIT];
          single_q   <= in_byte[`RTA_FMT_SINGLE_BIT];
          data_ph_q  <= 1'b1;
          out_sh_q   <= reg_read(in_byte[7:4]);
          ser_sio_oe <= in_byte[`RTA_FMT_READ_BIT];
        end
        else if (single_q)
        begin
          data_ph_q  <= 1'b0;
          ser_sio_oe <= 1'b0;
        end
        else
        begin
          addr_q   <= addr_nx;
          out_sh_q <= reg_read(addr_nx);
        end
      end
    end
  end

  // Write strobe for a completed data byte of a write transfer.
  wire       wr_stb  = byte_end & data_ph_q & ~rd_q;
  wire [3:0] wr_addr = addr_q;
  wire [7:0] wr_data = in_byte;
  wire       trim_wr = wr_stb & (wr_addr == `RTA_ADDR_TRIM);

  // Register writes; bits with no storage are dropped.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_q       <= `RTA_TRIM_RESET;
      wk_minute_q  <= `RTA_ALARM_RESET;
      wk_hour_q    <= 6'h00;
      wk_daymask_q <= `RTA_ALARM_RESET;
      dy_minute_q  <= `RTA_ALARM_RESET;
      dy_hour_q    <= 6'h00;
    end
    else if (wr_stb)
    begin
      case (wr_addr)
        `RTA_ADDR_TRIM:       trim_q       <= wr_data;
        `RTA_ADDR_WK_MINUTE:  wk_minute_q  <= wr_data[6:0];
        `RTA_ADDR_WK_HOUR:    wk_hour_q    <= wr_data[5:0];
        `RTA_ADDR_WK_DAYMASK: wk_daymask_q <= wr_data[6:0];
        `RTA_ADDR_DY_MINUTE:  dy_minute_q  <= wr_data[6:0];
        `RTA_ADDR_DY_HOUR:    dy_hour_q    <= wr_data[5:0];
        default:              trim_q       <= trim_q;
      endcase
    end
  end

  // ****************************************************************
  // Second length with trim correction.
  // ****************************************************************
  wire [5:0]  mag     = trim_q[5:0];
  wire [15:0] len_up  = {9'h000, mag - 6'h01, 1'b0};
  wire [15:0] len_dn  = {8'h00, {1'b0, ~mag} + 7'h01, 1'b0};
  wire [15:0] len_cor = (mag == 6'h00) ? PULSES_NOMINAL :
                        trim_q[`RTA_TRIM_SIGN_BIT] ? PULSES_NOMINAL - len_dn :
                        PULSES_NOMINAL + len_up;
  wire        sec_q00 = (sec_bcd == `RTA_SEC_00);
  wire        sec_qual = trim_q[`RTA_TRIM_SEL_BIT] ? sec_q00 :
                         (sec_q00 || sec_bcd == `RTA_SEC_20 ||
                          sec_bcd == `RTA_SEC_40);

  reg  [15:0] pulse_cnt_q;
  reg  [15:0] len_q;
  reg         load_q;
  reg         skip_q;
  reg         in_qual_q;

  // Counts oscillator pulses; the oscillator itself is never touched.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_cnt_q <= 16'h0000;
      second_tick <= 1'b0;
    end
    else
    begin
      second_tick <= 1'b0;
      if (osc_up)
      begin
        if (pulse_cnt_q >= len_q - 16'h0001)
        begin
          pulse_cnt_q <= 16'h0000;
          second_tick <= 1'b1;
        end
        else
          pulse_cnt_q <= pulse_cnt_q + 16'h0001;
      end
    end
  end

  // Length is chosen once the seconds counter shows the new second.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      len_q       <= PULSES_NOMINAL;
      load_q      <= 1'b0;
      skip_q      <= 1'b0;
      in_qual_q   <= 1'b0;
      trim_active <= 1'b0;
    end
    else
    begin
      load_q <= second_tick;
      if (trim_wr)
        skip_q <= 1'b1;
      else if (load_q)
        skip_q <= 1'b0;
      if (load_q)
      begin
        in_qual_q <= sec_qual;
        if (sec_qual && !skip_q && !trim_wr)
        begin
          len_q       <= len_cor;
          trim_active <= (len_cor != PULSES_NOMINAL);
        end
        else
        begin
          len_q       <= PULSES_NOMINAL;
          trim_active <= 1'b0;
        end
      end
      else if (trim_wr && in_qual_q)
      begin
        len_q       <= PULSES_NOMINAL;
        trim_active <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Alarm comparison.
  // ****************************************************************
  wire [7:0] day_mask_ext = {1'b0, wk_daymask_q};
  wire       day_hit      = day_mask_ext[cur_weekday];

  // Raw BCD compare, so 12-hour codes 12 and 32 match directly.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      weekly_alarm_match <= 1'b0;
      daily_alarm_match  <= 1'b0;
    end
    else
    begin
      weekly_alarm_match <= day_hit && (wk_daymask_q != 7'h00) &&
                            (cur_minute == wk_minute_q) &&
                            (cur_hour == wk_hour_q);
      daily_alarm_match  <= (cur_minute == dy_minute_q) &&
                            (cur_hour == dy_hour_q);
    end
  end

endmodule // rta_trim_alarm

//--- verilog/rta_trim_alarm_map.vh
`ifndef RTA_TRIM_ALARM_MAP_VH
`define RTA_TRIM_ALARM_MAP_VH

// ****************************************************************
// Register addresses on the serial link.
// ****************************************************************
`define RTA_ADDR_TRIM        4'h7
`define RTA_ADDR_WK_MINUTE   4'h8
`define RTA_ADDR_WK_HOUR     4'h9
`define RTA_ADDR_WK_DAYMASK  4'hA
`define RTA_ADDR_DY_MINUTE   4'hB
`define RTA_ADDR_DY_HOUR     4'hC

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define RTA_TRIM_SEL_BIT     7
`define RTA_TRIM_SIGN_BIT    6
`define RTA_TRIM_RESET       8'h00
`define RTA_ALARM_RESET      7'h00
`define RTA_MINUTE_MASK      8'h7F
`define RTA_HOUR_MASK        8'h3F
`define RTA_DAYMASK_MASK     8'h7F

// ****************************************************************
// Transfer format nibble of the command byte.
// ****************************************************************
`define RTA_FMT_READ_BIT     2
`define RTA_FMT_SINGLE_BIT   3

// ****************************************************************
// Timekeeping counts.
// ****************************************************************
`define RTA_PULSES_NOMINAL   16'h8000
`define RTA_SEC_00           7'h00
`define RTA_SEC_20           7'h20
`define RTA_SEC_40           7'h40

`endif

//--- dv/rta_trim_alarm_props.sv
// ****************************************
// Port checker for the trim and alarm block.
// ****************************************
module rta_trim_alarm_props #(parameter [16:0] NOMINAL = 17'h08000) (
  input wire       clk,
  input wire       resetn,
  input wire       ser_ce,
  input wire       ser_sio_oe,
  input wire       osc_in,
  input wire [6:0] sec_bcd,
  input wire [6:0] cur_minute,
  input wire [5:0] cur_hour,
  input wire [2:0] cur_weekday,
  input wire       second_tick,
  input wire       weekly_alarm_match,
  input wire       daily_alarm_match,
  input wire       trim_active
);
  timeunit 1ns;
  timeprecision 1ps;
  reg        osc_q;
  reg        armed_q;
  reg        seen_q;
  reg [16:0] cnt_q;
  wire       rise = osc_in && !osc_q;
  // Counts oscillator pulses per second; the first second after reset is partial.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_q   <= 1'b0;
      armed_q <= 1'b0;
      seen_q  <= 1'b0;
      cnt_q   <= 17'h00000;
    end
    else
    begin
      osc_q   <= osc_in;
      armed_q <= armed_q | second_tick;
      seen_q  <= second_tick ? 1'b0 : (seen_q | (trim_active && !$past(second_tick)));
      cnt_q   <= second_tick ? {16'h0000, rise} : cnt_q + {16'h0000, rise};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence quiet_s;
    !ser_ce && $stable(cur_minute) && $stable(cur_hour) && $stable(cur_weekday);
  endsequence
  sequence end_sec_s;
    second_tick && armed_q;
  endsequence
  tick_pulse_a: assert property (second_tick |=> !second_tick)
    else $error("second tick lasted more than one cycle");
  nominal_len_a: assert property (end_sec_s ##0 (!seen_q && !trim_active) |-> cnt_q == NOMINAL)
    else $error("untrimmed second is not nominal length");
  trim_range_a: assert property (end_sec_s |-> cnt_q >= NOMINAL - 17'h0007E && cnt_q <= NOMINAL + 17'h0007C)
    else $error("second length outside trim range");
  sec_qual_a: assert property ($rose(trim_active) |-> $past(sec_bcd) inside {7'h00, 7'h20, 7'h40})
    else $error("trim applied in a non qualifying second");
  weekday_none_a: assert property (cur_weekday == 3'h7 |=> !weekly_alarm_match)
    else $error("weekly match on weekday seven");
  oe_release_a: assert property (!ser_ce [*4] |-> !ser_sio_oe)
    else $error("data line driven while not selected");
  oe_start_a: assert property ($rose(ser_sio_oe) |-> ser_ce && $past(ser_ce, 4))
    else $error("data line driven without a command");
  quiet_match_a: assert property (quiet_s [*3] |-> $stable(weekly_alarm_match) && $stable(daily_alarm_match))
    else $error("alarm match moved with steady inputs");
endmodule // rta_trim_alarm_props

bind rta_trim_alarm rta_trim_alarm_props #(.NOMINAL({1'b0, PULSES_NOMINAL})) i_props (
  .clk(clk), .resetn(resetn), .ser_ce(ser_ce), .ser_sio_oe(ser_sio_oe), .osc_in(osc_in),
  .sec_bcd(sec_bcd), .cur_minute(cur_minute), .cur_hour(cur_hour), .cur_weekday(cur_weekday),
  .second_tick(second_tick), .weekly_alarm_match(weekly_alarm_match),
  .daily_alarm_match(daily_alarm_match), .trim_active(trim_active));

//--- dv/rta_host_model.sv
// ****************************************
// Host side of the three wire link.
// ****************************************
module rta_host_model (
  input  wire clk,
  output reg  ser_ce,
  output reg  ser_sclk,
  output wire ser_sio_i,
  input  wire ser_sio_o,
  input  wire ser_sio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  reg host_bit;
  // The shared wire; an idle host keeps flipping so stale data never reads back.
  assign ser_sio_i = ser_sio_oe ? ser_sio_o : host_bit;
  initial
  begin
    ser_ce = 1'b0;
    ser_sclk = 1'b0;
    host_bit = 1'b0;
  end
  task automatic half;
    repeat (10) @(negedge clk);
  endtask
  // One session with clock low at select: bits in on the fall, out on the rise.
  task automatic xfer(input [7:0] cmd, input [7:0] wdata, output [7:0] rdata);
    integer i;
    begin
      ser_ce = 1'b1;
      half;
      for (i = 15; i >= 0; i = i - 1)
      begin
        ser_sclk = 1'b1;
        host_bit = (i > 7) ? cmd[i-8] : (cmd[2] ? ~host_bit : wdata[i]);
        half;
        if (i <= 7)
          rdata[i] = ser_sio_i;
        ser_sclk = 1'b0;
        half;
      end
      ser_ce = 1'b0;
      host_bit = ~host_bit;
      half;
    end
  endtask
endmodule // rta_host_model

//--- dv/tb_top.sv
// ****************************************
// Self checking bench.
// ****************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg        clk = 1'b0;
  reg        resetn = 1'b0;
  reg        osc_in = 1'b0;
  reg [6:0]  sec_bcd = 7'h01;
  reg [6:0]  cur_minute = 7'h59;
  reg [5:0]  cur_hour = 6'h01;
  reg [2:0]  cur_weekday = 3'h0;
  reg [17:0] cyc_q = 18'h00000;
  reg [17:0] len_q = 18'h00000;
  reg [7:0]  rv;
  // Short second so the trim scenarios fit the cycle budget.
  localparam [16:0] NOM = 17'h00200;
  wire       trim_act;
  wire       ser_ce;
  wire       ser_sclk;
  wire       ser_sio_i;
  wire       ser_sio_o;
  wire       ser_sio_oe;
  wire       second_tick;
  wire       weekly_match;
  wire       daily_match;
  integer    failures = 0;
  integer    tests_run = 0;
  // Fast oscillator: one pulse every two cycles keeps a second short.
  always #4 clk = ~clk;
  always @(negedge clk) osc_in <= ~osc_in;
  // Cycles between second ticks.
  always @(posedge clk)
  begin
    cyc_q <= second_tick ? 18'h00001 : cyc_q + 18'h00001;
    if (second_tick)
      len_q <= cyc_q;
  end
  rta_trim_alarm #(.PULSES_NOMINAL(NOM[15:0])) i_dut (.clk(clk), .resetn(resetn), .ser_ce(ser_ce), .ser_sclk(ser_sclk),
    .ser_sio_i(ser_sio_i), .ser_sio_o(ser_sio_o), .ser_sio_oe(ser_sio_oe), .osc_in(osc_in),
    .sec_bcd(sec_bcd), .cur_minute(cur_minute), .cur_hour(cur_hour), .cur_weekday(cur_weekday),
    .second_tick(second_tick), .weekly_alarm_match(weekly_match), .daily_alarm_match(daily_match),
    .trim_active(trim_act));
  rta_host_model i_host (.clk(clk), .ser_ce(ser_ce), .ser_sclk(ser_sclk), .ser_sio_i(ser_sio_i),
    .ser_sio_o(ser_sio_o), .ser_sio_oe(ser_sio_oe));
  task test_done;
    begin
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task automatic check(input string what, input [17:0] seen, input [17:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task automatic wr(input [3:0] a, input [7:0] d);
    i_host.xfer({a, 4'h8}, d, rv);
  endtask
  task automatic rd(input [3:0] a, input [7:0] exp);
    begin
      i_host.xfer({a, 4'hC}, 8'h00, rv);
      check("register", {10'h000, rv}, {10'h000, exp});
    end
  endtask
  task automatic wr_rd(input [3:0] a, input [7:0] d, input [7:0] exp);
    begin
      wr(a, d);
      rd(a, exp);
    end
  endtask
  // Presents a time and judges both match outputs once they settle.
  task automatic al(input [2:0] wd, input [6:0] mi, input [5:0] hr, input ew, input ed);
    begin
      cur_weekday = wd;
      cur_minute = mi;
      cur_hour = hr;
      repeat (3) @(negedge clk);
      check("weekly match", {17'h00000, weekly_match}, {17'h00000, ew});
      check("daily match", {17'h00000, daily_match}, {17'h00000, ed});
    end
  endtask
  // Waits for a second tick under a bound, then checks the second that ended.
  task automatic measure(input [6:0] nxt, input [16:0] pulses);
    integer n;
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n = n + 1;
      end
      while (second_tick !== 1'b1 && n < 3000);
      if (n >= 3000)
      begin
        failures = failures + 1;
        test_done;
      end
      // The seconds counter must move before the new length is chosen.
      @(negedge clk);
      sec_bcd = nxt;
      check("second length", len_q, {pulses, 1'b0});
      check("trim active", {17'h00000, trim_act}, {17'h00000, pulses != NOM});
    end
  endtask
  task automatic t_reset_values;
    integer a;
    for (a = 7; a <= 12; a = a + 1)
      rd(a[3:0], 8'h00);
  endtask
  task automatic t_masking;
    begin
      wr_rd(4'h7, 8'hC5, 8'hC5);
      wr_rd(4'h8, 8'hFF, 8'h7F);
      wr_rd(4'h9, 8'hFF, 8'h3F);
      wr_rd(4'hA, 8'hFF, 8'h7F);
      wr_rd(4'hB, 8'hD9, 8'h59);
      wr_rd(4'hC, 8'hF2, 8'h32);
      wr_rd(4'hD, 8'h5A, 8'h00);
      wr(4'h7, 8'h00);
    end
  endtask
  // Valid times apart from weekday 7, which has no mask bit; noon in twelve hour form is 32.
  task automatic t_alarms;
    begin
      wr(4'h8, 8'h59);
      wr(4'h9, 8'h32);
      wr(4'hA, 8'h7F);
      wr(4'hB, 8'h30);
      wr(4'hC, 8'h12);
      al(3'h3, 7'h59, 6'h32, 1'b1, 1'b0);
      al(3'h7, 7'h59, 6'h32, 1'b0, 1'b0);
      wr(4'hA, 8'h00);
      al(3'h3, 7'h59, 6'h32, 1'b0, 1'b0);
      wr(4'hA, 8'h08);
      al(3'h3, 7'h59, 6'h32, 1'b1, 1'b0);
      al(3'h2, 7'h59, 6'h32, 1'b0, 1'b0);
      al(3'h2, 7'h30, 6'h12, 1'b0, 1'b1);
    end
  endtask
  // A write in a qualifying second, or the one before it, leaves that second nominal.
  task automatic t_trim;
    begin
      measure(7'h20, NOM);
      wr(4'h7, 8'h07);
      measure(7'h40, NOM);
      measure(7'h00, NOM);
      measure(7'h01, NOM + 17'h0000C);
      measure(7'h40, NOM);
      measure(7'h20, NOM + 17'h0000C);
      wr(4'h7, 8'hFE);
      measure(7'h00, NOM);
      measure(7'h20, NOM);
      measure(7'h00, NOM);
      measure(7'h01, NOM - 17'h00004);
    end
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    t_reset_values;
    t_masking;
    t_alarms;
    t_trim;
    test_done;
  end
endmodule // tb_top
